// ===== hdl/ieb_bank.v
// interrupt enable bank with flags, priorities and arbitration feed
// assumes apb master on core_clk and source requests on the same clock
`timescale 1ns/1ps
`include "ieb_map.vh"

module ieb_bank (
  // clock and reset
  input  wire                               core_clk,
  input  wire                               rst,
  // apb slave
  input  wire                               psel,
  input  wire                               penable,
  input  wire                               pwrite,
  input  wire [`IEB_ADDR_W-1:0]             paddr,
  input  wire [`IEB_DATA_W-1:0]             pwdata,
  output reg  [`IEB_DATA_W-1:0]             prdata,
  output wire                               pready,
  output reg                                pslverr,
  // source requests
  input  wire [`IEB_NSRC-1:0]               src_req,
  // gated requests
  output wire [`IEB_NSRC-1:0]               src_gated,
  // arbitration
  output wire                               arb_valid,
  output wire [`IEB_ID_W-1:0]               arb_id,
  output wire [`IEB_PRIO_W-1:0]             arb_level,
  // interrupt
  output wire                               irq
);

  ////////////////////////////////////////////////////////////////////////
  // source map lookups

  function [2:0] src_reg;
    input integer s;
    begin
      case (s)
        0:       src_reg = `IEB_S0_REG;
        1:       src_reg = `IEB_S1_REG;
        2:       src_reg = `IEB_S2_REG;
        3:       src_reg = `IEB_S3_REG;
        4:       src_reg = `IEB_S4_REG;
        5:       src_reg = `IEB_S5_REG;
        6:       src_reg = `IEB_S6_REG;
        7:       src_reg = `IEB_S7_REG;
        8:       src_reg = `IEB_S8_REG;
        9:       src_reg = `IEB_S9_REG;
        10:      src_reg = `IEB_S10_REG;
        11:      src_reg = `IEB_S11_REG;
        12:      src_reg = `IEB_S12_REG;
        13:      src_reg = `IEB_S13_REG;
        14:      src_reg = `IEB_S14_REG;
        15:      src_reg = `IEB_S15_REG;
        16:      src_reg = `IEB_S16_REG;
        17:      src_reg = `IEB_S17_REG;
        18:      src_reg = `IEB_S18_REG;
        default: src_reg = `IEB_S0_REG;
      endcase
    end
  endfunction

  function [3:0] src_bit;
    input integer s;
    begin
      case (s)
        0:       src_bit = `IEB_S0_BIT;
        1:       src_bit = `IEB_S1_BIT;
        2:       src_bit = `IEB_S2_BIT;
        3:       src_bit = `IEB_S3_BIT;
        4:       src_bit = `IEB_S4_BIT;
        5:       src_bit = `IEB_S5_BIT;
        6:       src_bit = `IEB_S6_BIT;
        7:       src_bit = `IEB_S7_BIT;
        8:       src_bit = `IEB_S8_BIT;
        9:       src_bit = `IEB_S9_BIT;
        10:      src_bit = `IEB_S10_BIT;
        11:      src_bit = `IEB_S11_BIT;
        12:      src_bit = `IEB_S12_BIT;
        13:      src_bit = `IEB_S13_BIT;
        14:      src_bit = `IEB_S14_BIT;
        15:      src_bit = `IEB_S15_BIT;
        16:      src_bit = `IEB_S16_BIT;
        17:      src_bit = `IEB_S17_BIT;
        18:      src_bit = `IEB_S18_BIT;
        default: src_bit = `IEB_S0_BIT;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire [`IEB_IDX_W-1:0] widx;
  wire                  setup_ph;
  wire                  access_ph;
  wire                  wr;
  wire                  rd;

  assign widx      = paddr[`IEB_ADDR_W-1:2];
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr        = access_ph & pwrite;
  assign rd        = access_ph & ~pwrite;
  assign pready    = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // register selects; index 2 of the enable and flag banks is a hole

  wire [`IEB_IDX_W-1:0] en_rel;
  wire [`IEB_IDX_W-1:0] fl_rel;
  wire [`IEB_IDX_W-1:0] pr_rel;
  wire                  sel_en;
  wire                  sel_flag;
  wire                  sel_prio;
  wire                  sel_stat;
  wire                  sel_mask;
  wire                  sel_arb;

  assign en_rel   = widx - `IEB_IDX_EN;
  assign fl_rel   = widx - `IEB_IDX_FLAG;
  assign pr_rel   = widx - `IEB_IDX_PRIO;
  assign sel_en   = (widx < `IEB_IDX_EN + `IEB_NREG) &&
                    (en_rel != `IEB_REG_GAP);
  assign sel_flag = (widx >= `IEB_IDX_FLAG) &&
                    (widx < `IEB_IDX_FLAG + `IEB_NREG) &&
                    (fl_rel != `IEB_REG_GAP);
  assign sel_prio = (widx >= `IEB_IDX_PRIO) &&
                    (widx < `IEB_IDX_PRIO + `IEB_NPRIO_WORDS);
  assign sel_stat = (widx == `IEB_IDX_STAT);
  assign sel_mask = (widx == `IEB_IDX_MASK);
  assign sel_arb  = (widx == `IEB_IDX_ARB);

  ////////////////////////////////////////////////////////////////////////
  // per-source state

  reg  [`IEB_NSRC-1:0]             en;
  reg  [`IEB_NSRC-1:0]             flag;
  reg  [`IEB_NSRC*`IEB_PRIO_W-1:0] prio;
  wire [`IEB_NSRC-1:0]             pend;

  genvar i;
  generate
    for (i = 0; i < `IEB_NSRC; i = i + 1) begin : g_src
      localparam [2:0]  RN  = src_reg(i);
      localparam [3:0]  BP  = src_bit(i);
      localparam integer PW = i / `IEB_PRIO_PER_WD;
      localparam integer PF = (i % `IEB_PRIO_PER_WD) * `IEB_PRIO_STRIDE;
      localparam [`IEB_IDX_W-1:0] EN_IDX = `IEB_IDX_EN + {3'h0, RN};
      localparam [`IEB_IDX_W-1:0] FL_IDX = `IEB_IDX_FLAG + {3'h0, RN};
      localparam [`IEB_IDX_W-1:0] PR_IDX = `IEB_IDX_PRIO + PW[5:0];

      wire en_wr;
      wire fl_wr;
      wire pr_wr;

      assign en_wr = wr && (widx == EN_IDX);
      assign fl_wr = wr && (widx == FL_IDX);
      assign pr_wr = wr && (widx == PR_IDX);

      always @(posedge core_clk) begin
        if (rst) begin
          en[i] <= 1'b0;
        end else if (en_wr) begin
          en[i] <= pwdata[BP];
        end
      end

      // a request in the write cycle wins over a software clear
      always @(posedge core_clk) begin
        if (rst) begin
          flag[i] <= 1'b0;
        end else if (fl_wr) begin
          flag[i] <= pwdata[BP] | src_req[i];
        end else if (src_req[i]) begin
          flag[i] <= 1'b1;
        end
      end

      always @(posedge core_clk) begin
        if (rst) begin
          prio[i*`IEB_PRIO_W +: `IEB_PRIO_W] <= `IEB_PRIO_RST;
        end else if (pr_wr) begin
          prio[i*`IEB_PRIO_W +: `IEB_PRIO_W] <=
            pwdata[PF +: `IEB_PRIO_W];
        end
      end

      // enable clear leaves the flag alone
      assign pend[i] = flag[i] & en[i];
    end
  endgenerate

  assign src_gated = pend;

  ////////////////////////////////////////////////////////////////////////
  // read words; positions not mapped to a source stay zero

  reg [`IEB_NREG*`IEB_REG_W-1:0]           en_rd;
  reg [`IEB_NREG*`IEB_REG_W-1:0]           flag_rd;
  reg [`IEB_NPRIO_WORDS*`IEB_DATA_W-1:0]   prio_rd;
  integer                                  k;

  always @* begin
    en_rd   = {(`IEB_NREG*`IEB_REG_W){1'b0}};
    flag_rd = {(`IEB_NREG*`IEB_REG_W){1'b0}};
    prio_rd = {(`IEB_NPRIO_WORDS*`IEB_DATA_W){1'b0}};
    for (k = 0; k < `IEB_NSRC; k = k + 1) begin
      en_rd[src_reg(k)*`IEB_REG_W + src_bit(k)]   = en[k];
      flag_rd[src_reg(k)*`IEB_REG_W + src_bit(k)] = flag[k];
      prio_rd[(k / `IEB_PRIO_PER_WD)*`IEB_DATA_W +
              (k % `IEB_PRIO_PER_WD)*`IEB_PRIO_STRIDE +: `IEB_PRIO_W] =
        prio[k*`IEB_PRIO_W +: `IEB_PRIO_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration

  ieb_arb u_arb (
    .core_clk  (core_clk),
    .rst       (rst),
    .pend      (pend),
    .prio      (prio),
    .arb_valid (arb_valid),
    .arb_id    (arb_id),
    .arb_level (arb_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and line

  reg  [`IEB_IRQ_W-1:0] stat;
  reg  [`IEB_IRQ_W-1:0] mask;
  reg  [`IEB_IRQ_W-1:0] stat_seen;
  reg                   arb_valid_d;
  wire [`IEB_IRQ_W-1:0] ev;
  wire                  rd_stat;
  wire                  arb_rise;
  wire [`IEB_NSRC-1:0]  blk_req;

  assign arb_rise         = arb_valid & ~arb_valid_d;
  assign blk_req          = src_req & ~en;
  assign ev[`IEB_IRQ_ARB] = arb_rise;
  assign ev[`IEB_IRQ_BLK] = |blk_req;
  assign rd_stat          = rd & sel_stat;
  assign irq              = |(stat & mask);

  // clear only what the read returned; new events still land
  always @(posedge core_clk) begin
    if (rst) begin
      stat        <= {`IEB_IRQ_W{1'b0}};
      arb_valid_d <= 1'b0;
    end else begin
      arb_valid_d <= arb_valid;
      if (rd_stat) begin
        stat <= (stat & ~stat_seen) | ev;
      end else begin
        stat <= stat | ev;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      mask <= {`IEB_IRQ_W{1'b0}};
    end else if (wr && sel_mask) begin
      mask <= pwdata[`IEB_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and error, captured in the setup cycle

  reg [`IEB_DATA_W-1:0] next_rdata;
  reg                   next_err;

  always @* begin
    next_rdata = {`IEB_DATA_W{1'b0}};
    next_err   = 1'b0;
    if (sel_en) begin
      next_rdata[`IEB_REG_W-1:0] =
        en_rd[en_rel[2:0]*`IEB_REG_W +: `IEB_REG_W];
    end else if (sel_flag) begin
      next_rdata[`IEB_REG_W-1:0] =
        flag_rd[fl_rel[2:0]*`IEB_REG_W +: `IEB_REG_W];
    end else if (sel_prio) begin
      next_rdata = prio_rd[pr_rel[1:0]*`IEB_DATA_W +: `IEB_DATA_W];
    end else if (sel_stat) begin
      next_rdata[`IEB_IRQ_W-1:0] = stat;
    end else if (sel_mask) begin
      next_rdata[`IEB_IRQ_W-1:0] = mask;
    end else if (sel_arb) begin
      next_rdata[`IEB_ARB_ID_LSB +: `IEB_ID_W]   = arb_id;
      next_rdata[`IEB_ARB_LV_LSB +: `IEB_PRIO_W] = arb_level;
      next_rdata[`IEB_ARB_VALID]                 = arb_valid;
    end else begin
      next_err = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= {`IEB_DATA_W{1'b0}};
    end else if (setup_ph) begin
      prdata <= pwrite ? {`IEB_DATA_W{1'b0}} : next_rdata;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= next_err;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // snapshot of what the read returns, so only that is cleared
  always @(posedge core_clk) begin
    if (rst) begin
      stat_seen <= {`IEB_IRQ_W{1'b0}};
    end else if (setup_ph) begin
      stat_seen <= stat;
    end
  end

endmodule

// ===== hdl/ieb_map.vh
// constants for the interrupt enable bank: word indices, source map, fields
// assumes an apb slave with 32-bit data and byte addresses on paddr[7:0]
`ifndef IEB_MAP_VH
`define IEB_MAP_VH

// bus geometry
`define IEB_ADDR_W      8
`define IEB_IDX_W       6
`define IEB_DATA_W      32
`define IEB_REG_W       16

// word indices (byte address is four times the index)
`define IEB_IDX_EN      6'h00
`define IEB_IDX_FLAG    6'h08
`define IEB_IDX_PRIO    6'h10
`define IEB_IDX_STAT    6'h14
`define IEB_IDX_MASK    6'h15
`define IEB_IDX_ARB     6'h16
`define IEB_NREG        7
`define IEB_REG_GAP     6'h02
`define IEB_NPRIO_WORDS 3

// sources
`define IEB_NSRC        19
`define IEB_ID_W        5
`define IEB_PRIO_W      3
`define IEB_PRIO_RST    3'h4
`define IEB_PRIO_OFF    3'h0
`define IEB_PRIO_PER_WD 8
`define IEB_PRIO_STRIDE 4

// source map: register number and bit position
`define IEB_S0_REG  3'h0
`define IEB_S0_BIT  4'h0
`define IEB_S1_REG  3'h0
`define IEB_S1_BIT  4'h1
`define IEB_S2_REG  3'h1
`define IEB_S2_BIT  4'h0
`define IEB_S3_REG  3'h1
`define IEB_S3_BIT  4'h1
`define IEB_S4_REG  3'h1
`define IEB_S4_BIT  4'h2
`define IEB_S5_REG  3'h1
`define IEB_S5_BIT  4'h3
`define IEB_S6_REG  3'h1
`define IEB_S6_BIT  4'h4
`define IEB_S7_REG  3'h1
`define IEB_S7_BIT  4'hD
`define IEB_S8_REG  3'h3
`define IEB_S8_BIT  4'h9
`define IEB_S9_REG  3'h4
`define IEB_S9_BIT  4'h1
`define IEB_S10_REG 3'h5
`define IEB_S10_BIT 4'hE
`define IEB_S11_REG 3'h5
`define IEB_S11_BIT 4'hF
`define IEB_S12_REG 3'h6
`define IEB_S12_BIT 4'h0
`define IEB_S13_REG 3'h6
`define IEB_S13_BIT 4'h1
`define IEB_S14_REG 3'h6
`define IEB_S14_BIT 4'h7
`define IEB_S15_REG 3'h6
`define IEB_S15_BIT 4'h8
`define IEB_S16_REG 3'h6
`define IEB_S16_BIT 4'h9
`define IEB_S17_REG 3'h6
`define IEB_S17_BIT 4'hE
`define IEB_S18_REG 3'h6
`define IEB_S18_BIT 4'hF

// interrupt status bits
`define IEB_IRQ_W       2
`define IEB_IRQ_ARB     0
`define IEB_IRQ_BLK     1

// arbitration result word fields
`define IEB_ARB_ID_LSB  0
`define IEB_ARB_LV_LSB  8
`define IEB_ARB_VALID   16

`endif

// ===== hdl/ieb_arb.v
// highest-priority pick among pending enabled sources
// assumes pend and prio come from flops on the same clock
`timescale 1ns/1ps
`include "ieb_map.vh"

module ieb_arb (
  // clock and reset
  input  wire                                  core_clk,
  input  wire                                  rst,
  // candidates
  input  wire [`IEB_NSRC-1:0]                  pend,
  input  wire [`IEB_NSRC*`IEB_PRIO_W-1:0]      prio,
  // result
  output reg                                   arb_valid,
  output reg  [`IEB_ID_W-1:0]                  arb_id,
  output reg  [`IEB_PRIO_W-1:0]                arb_level
);

  reg [`IEB_ID_W-1:0]   next_id;
  reg [`IEB_PRIO_W-1:0] next_level;
  integer               k;

  ////////////////////////////////////////////////////////////////////////
  // strict compare keeps the lowest index on a tie
  always @* begin
    next_id    = {`IEB_ID_W{1'b0}};
    next_level = `IEB_PRIO_OFF;
    for (k = 0; k < `IEB_NSRC; k = k + 1) begin
      if (pend[k] &&
          prio[k*`IEB_PRIO_W +: `IEB_PRIO_W] > next_level) begin
        next_level = prio[k*`IEB_PRIO_W +: `IEB_PRIO_W];
        next_id    = k[`IEB_ID_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (rst) begin
      arb_valid <= 1'b0;
      arb_id    <= {`IEB_ID_W{1'b0}};
      arb_level <= `IEB_PRIO_OFF;
    end else begin
      arb_valid <= (next_level != `IEB_PRIO_OFF);
      arb_id    <= next_id;
      arb_level <= next_level;
    end
  end

endmodule

// ===== tb/ieb_bank_asserts.sv
// assertions on the ports of the interrupt enable bank
// assumes apb transfers and source requests on core_clk, rst sync high
`timescale 1ns/1ps
`include "ieb_map.vh"

module ieb_chk (
  // clock and reset
  input wire                 core_clk,
  input wire                 rst,
  // apb slave
  input wire                 psel,
  input wire                 penable,
  input wire                 pwrite,
  input wire [`IEB_ADDR_W-1:0] paddr,
  input wire [`IEB_DATA_W-1:0] prdata,
  input wire                 pslverr,
  // sources and arbitration
  input wire [`IEB_NSRC-1:0] src_req,
  input wire [`IEB_NSRC-1:0] src_gated,
  input wire                 arb_valid,
  input wire [`IEB_ID_W-1:0] arb_id,
  input wire [`IEB_PRIO_W-1:0] arb_level,
  input wire                 irq
);
  reg  [`IEB_NSRC-1:0] gated_q;
  wire [5:0]           idx = paddr[7:2];

  // implemented bits per enable or flag register
  function [15:0] live(input [5:0] i);
    case (i[2:0])
      3'h0: live = 16'h0003;
      3'h1: live = 16'h201F;
      3'h3: live = 16'h0200;
      3'h4: live = 16'h0002;
      3'h5: live = 16'hC000;
      3'h6: live = 16'hC383;
      default: live = 16'h0000;
    endcase
  endfunction

  always @(posedge core_clk) begin
    gated_q <= src_gated;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  sequence s_quiet;
    src_req == 0 && !psel;
  endsequence

  chk_rst_clears: assert property (
    $fell(rst) |-> src_gated == 0 && !irq && !arb_valid && prdata == 0)
    else $error("outputs not clear after reset");
  chk_gate_cause: assert property (
    s_quiet ##0 src_gated == 0 |=> src_gated == 0)
    else $error("gated request without cause");
  chk_gate_holds: assert property (
    !(psel && penable && pwrite) |=>
      (src_gated & $past(src_gated)) == $past(src_gated))
    else $error("gated request dropped without write");
  chk_arb_pending: assert property (
    arb_valid |-> gated_q[arb_id])
    else $error("winner was not flagged and enabled");
  chk_arb_level: assert property (
    arb_valid |-> arb_level != 3'h0)
    else $error("winner with priority zero");
  chk_absent_zero: assert property (
    s_rd ##0 idx < 6'h0F |-> (prdata & ~{16'h0000, live(idx)}) == 0)
    else $error("absent bit read as one");
  chk_unmapped_err: assert property (
    psel && penable && (idx == 6'h02 || idx == 6'h0A) |->
      pslverr && prdata == 0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (
    psel && penable && idx < 6'h0F && idx[2:0] != 3'h2 &&
      idx[2:0] != 3'h7 |-> !pslverr)
    else $error("mapped access refused");
endmodule

bind ieb_bank ieb_chk u_ieb_chk (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .src_req(src_req), .src_gated(src_gated), .arb_valid(arb_valid),
  .arb_id(arb_id), .arb_level(arb_level), .irq(irq)
);

// ===== tb/tb_top.sv
// self-checking bench for the interrupt enable bank
// assumes ieb_bank and its checker are compiled before this file
`timescale 1ns/1ps
`include "ieb_map.vh"
`define CHK(g, e) chk_eq(32'(g), 32'(e))

module tb_top;
  reg                  core_clk = 1'b0;
  reg                  rst      = 1'b1;
  reg                  psel     = 1'b0;
  reg                  penable  = 1'b0;
  reg                  pwrite   = 1'b0;
  reg  [7:0]           paddr    = 8'h00;
  reg  [31:0]          pwdata   = 32'h0;
  reg  [`IEB_NSRC-1:0] src_req  = 19'h0;
  wire [31:0]          prdata;
  wire                 pready, pslverr, arb_valid, irq;
  wire [`IEB_NSRC-1:0] src_gated;
  wire [4:0]           arb_id;
  wire [2:0]           arb_level;
  reg  [31:0]          rdat, seed, d;
  reg                  rerr;
  reg  [6:0]           m;
  int                  n_mismatch, checks, i, n;

  ieb_bank u_ieb_bank (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req),
    .src_gated(src_gated), .arb_valid(arb_valid), .arb_id(arb_id),
    .arb_level(arb_level), .irq(irq)
  );

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function [15:0] imask(input [5:0] k);
    case (k[2:0])
      3'h0: imask = 16'h0003;
      3'h1: imask = 16'h201F;
      3'h3: imask = 16'h0200;
      3'h4: imask = 16'h0002;
      3'h5: imask = 16'hC000;
      3'h6: imask = 16'hC383;
      default: imask = 16'h0000;
    endcase
  endfunction

  // source to register number and bit
  function [6:0] smap(input [4:0] k);
    case (k)
      5'h00: smap = 7'h00;
      5'h01: smap = 7'h01;
      5'h02: smap = 7'h10;
      5'h03: smap = 7'h11;
      5'h04: smap = 7'h12;
      5'h05: smap = 7'h13;
      5'h06: smap = 7'h14;
      5'h07: smap = 7'h1D;
      5'h08: smap = 7'h39;
      5'h09: smap = 7'h41;
      5'h0A: smap = 7'h5E;
      5'h0B: smap = 7'h5F;
      5'h0C: smap = 7'h60;
      5'h0D: smap = 7'h61;
      5'h0E: smap = 7'h67;
      5'h0F: smap = 7'h68;
      5'h10: smap = 7'h69;
      5'h11: smap = 7'h6E;
      default: smap = 7'h6F;
    endcase
  endfunction

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task chk_eq(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task apb(input bit w, input [7:0] a, input [31:0] v);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task pulse(input [`IEB_NSRC-1:0] v);
    @(posedge core_clk);
    src_req <= v;
    @(posedge core_clk);
    src_req <= 19'h0;
    repeat (3) @(posedge core_clk);
  endtask

  task clr;
    for (n = 0; n < 15; n++) begin
      if (imask(n) != 0) apb(1, 8'(4 * n), 0);
    end
  endtask

  task results;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    results;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hEF41B3C3;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (n = 0; n < 15; n++) begin
      if (imask(n) != 0) begin
        apb(0, 8'(4 * n), 0);
        `CHK(rdat, 0);
        apb(1, 8'(4 * n), 32'hFFFFFFFF);
        apb(0, 8'(4 * n), 0);
        `CHK(rdat, imask(n));
      end
    end
    for (i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      n = {seed[9], seed[2:0]};
      d = lfsr(seed ^ 32'h5A5A0000);
      if (imask(n) != 0) begin
        apb(1, 8'(4 * n), d);
        apb(0, 8'(4 * n), 0);
        `CHK(rdat, d & imask(n));
      end
    end
    clr;
    apb(1, 8'h08, 32'hFFFFFFFF);
    `CHK(rerr, 1);
    apb(0, 8'h08, 0);
    `CHK(rdat, 0);
    $display("test registers done");
    for (i = 0; i < `IEB_NSRC; i++) begin
      m = smap(i);
      pulse(1 << i);
      `CHK(src_gated, 0);
      apb(1, 8'(4 * m[6:4]), 32'(1) << m[3:0]);
      repeat (2) @(posedge core_clk);
      `CHK(src_gated, 1 << i);
      `CHK(arb_id, i);
      apb(1, 8'(4 * m[6:4]), 0);
      apb(0, 8'(4 * m[6:4] + 32), 0);
      `CHK(rdat, 32'(1) << m[3:0]);
      `CHK(src_gated, 0);
      apb(1, 8'(4 * m[6:4] + 32), 0);
    end
    $display("test gating done");
    apb(1, 8'h00, 32'h2);
    apb(1, 8'h04, 32'h8);
    apb(1, 8'h40, 32'h00700020);
    pulse(19'h22);
    `CHK(arb_id, 5);
    `CHK(arb_level, 7);
    apb(0, 8'h58, 0);
    `CHK(rdat, (1 << `IEB_ARB_VALID) | (7 << `IEB_ARB_LV_LSB) | 5);
    apb(0, 8'h40, 0);
    `CHK(rdat, 32'h00700020);
    apb(1, 8'h40, 32'h20);
    repeat (2) @(posedge core_clk);
    `CHK(arb_id, 1);
    `CHK(arb_level, 2);
    apb(1, 8'h40, 0);
    repeat (2) @(posedge core_clk);
    `CHK(arb_valid, 0);
    clr;
    $display("test priority done");
    apb(1, 8'h54, 0);
    apb(0, 8'h50, 0);
    pulse(19'h1);
    `CHK(irq, 0);
    apb(1, 8'h54, 32'h2);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1);
    apb(0, 8'h50, 0);
    `CHK(rdat, 2);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 0);
    apb(1, 8'h54, 32'h1);
    apb(1, 8'h40, 32'h1);
    apb(1, 8'h00, 32'h1);
    pulse(19'h1);
    `CHK(irq, 1);
    apb(0, 8'h50, 0);
    `CHK(rdat, 1);
    $display("test interrupt done");
    results;
  end
endmodule
